/* lpc_low_power_ctrl.sv */
// Low-power entry control register and core sleep sequencing behind APB
module lpc_low_power_ctrl #(
	parameter int NUM_IRQ = 32,
	parameter bit SEC_EXT = 1'b1
) (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [lpc_pkg::LPC_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [2:0] pprot_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	// Core execution status
	input wire logic wfe_exec_in,
	input wire logic wfi_exec_in,
	input wire logic exc_ret_thread_in,
	input wire logic cur_secure_in,
	// Event and interrupt sources
	input wire logic send_event_instr_in,
	input wire logic ext_event_in,
	input wire logic [NUM_IRQ-1:0] irq_pend_in,
	input wire logic [NUM_IRQ-1:0] irq_en_in,
	// Power status
	output logic core_halt_out,
	output logic deep_sleep_out,
	output logic wake_out,
	output logic event_latched_out
);
	import lpc_pkg::*;

	// -----------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------
	if (NUM_IRQ < 1 || NUM_IRQ > 480) begin : g_bad_irq
		$error("NUM_IRQ must lie between 1 and 480");
	end

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	lpc_state_e state_reg;
	lpc_state_e state_next;
	logic wake_any_s_reg;
	logic wake_any_ns_reg;
	logic soe_s_reg;
	logic soe_ns_reg;
	logic deep_sel_reg;
	logic lock_reg;
	logic deep_out_reg;
	logic wake_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic ext_sync1_reg;
	logic ext_sync2_reg;
	logic ext_prev_reg;

	// -----------------------------------------------------------------
	// APB decode
	// -----------------------------------------------------------------
	logic setup_ph;
	logic access_ph;
	logic hit_ctrl;
	logic hit_stat;
	logic sec_acc;
	logic deep_vis;
	logic wr_ctrl;
	logic wr_sec;
	logic wr_ns;
	logic wr_deep;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;
	logic [31:0] rd_mux;

	// Phases, address hits and security of the access
	assign setup_ph = psel_in & ~penable_in & ce_in;
	assign access_ph = psel_in & penable_in & ce_in;
	assign hit_ctrl = (paddr_in == LPC_CTRL_OFS);
	assign hit_stat = (paddr_in == LPC_STAT_OFS);
	assign sec_acc = ~SEC_EXT | ~pprot_in[1];
	assign deep_vis = sec_acc | ~lock_reg;

	// Write strobes; all fields sit in byte lane 0
	assign wr_ctrl = access_ph & pwrite_in & hit_ctrl & pstrb_in[0];
	assign wr_sec = wr_ctrl & sec_acc;
	assign wr_ns = wr_ctrl & ~sec_acc;
	assign wr_deep = wr_ctrl & deep_vis;

	// Read view of the control word; reserved bits stay zero
	always_comb begin
		ctrl_rd = LPC_WORD_RST;
		ctrl_rd[LPC_WAKE_BIT] = sec_acc ? wake_any_s_reg : wake_any_ns_reg;
		ctrl_rd[LPC_SOE_BIT] = sec_acc ? soe_s_reg : soe_ns_reg;
		ctrl_rd[LPC_DEEP_BIT] = deep_vis & deep_sel_reg;
		ctrl_rd[LPC_LOCK_BIT] = SEC_EXT & sec_acc & lock_reg;
	end

	// Read view of the status word
	always_comb begin
		stat_rd = LPC_WORD_RST;
		stat_rd[LPC_ST_SLEEP_BIT] = core_halt_out;
		stat_rd[LPC_ST_DEEP_BIT] = deep_out_reg;
		stat_rd[LPC_ST_WFE_BIT] = (state_reg == LPC_WFE);
		stat_rd[LPC_ST_EVT_BIT] = event_latched_out;
	end

	assign rd_mux = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : LPC_WORD_RST);

	// Zero-wait slave; read data captured in the setup cycle
	assign pready_out = ce_in;
	assign prdata_out = prdata_reg;
	assign pslverr_out = pslverr_reg & psel_in & penable_in;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_reg <= LPC_WORD_RST;
			pslverr_reg <= LPC_BIT_RST;
		end else if (setup_ph) begin
			prdata_reg <= pwrite_in ? LPC_WORD_RST : rd_mux;
			pslverr_reg <= ~(hit_ctrl | hit_stat);
		end
	end

	// -----------------------------------------------------------------
	// Control register
	// -----------------------------------------------------------------
	// Banked flags: each security state writes only its own copy
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_any_s_reg <= LPC_BIT_RST;
			soe_s_reg <= LPC_BIT_RST;
		end else if (wr_sec) begin
			wake_any_s_reg <= pwdata_in[LPC_WAKE_BIT];
			soe_s_reg <= pwdata_in[LPC_SOE_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_any_ns_reg <= LPC_BIT_RST;
			soe_ns_reg <= LPC_BIT_RST;
		end else if (wr_ns) begin
			wake_any_ns_reg <= pwdata_in[LPC_WAKE_BIT];
			soe_ns_reg <= pwdata_in[LPC_SOE_BIT];
		end
	end

	// Shared deep select, writable by whoever can see it
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			deep_sel_reg <= LPC_BIT_RST;
		end else if (wr_deep) begin
			deep_sel_reg <= pwdata_in[LPC_DEEP_BIT];
		end
	end

	// Shared lock, secure writes only, absent without the extension
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lock_reg <= LPC_BIT_RST;
		end else if (wr_sec) begin
			lock_reg <= SEC_EXT & pwdata_in[LPC_LOCK_BIT];
		end
	end

	// -----------------------------------------------------------------
	// External event pin synchroniser and edge detect
	// -----------------------------------------------------------------
	logic ext_rise;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ext_sync1_reg <= LPC_BIT_RST;
			ext_sync2_reg <= LPC_BIT_RST;
			ext_prev_reg <= LPC_BIT_RST;
		end else if (ce_in) begin
			ext_sync1_reg <= ext_event_in;
			ext_sync2_reg <= ext_sync1_reg;
			ext_prev_reg <= ext_sync2_reg;
		end
	end

	assign ext_rise = ext_sync2_reg & ~ext_prev_reg;

	// -----------------------------------------------------------------
	// Event generation
	// -----------------------------------------------------------------
	logic wake_any_act;
	logic soe_act;
	logic event_now;
	logic consume;
	logic irq_wake;

	// Flags of the security state the core runs in
	assign wake_any_act = (SEC_EXT & ~cur_secure_in) ? wake_any_ns_reg
		: wake_any_s_reg;
	assign soe_act = (SEC_EXT & ~cur_secure_in) ? soe_ns_reg : soe_s_reg;

	// A wait consumes the latch whether it halts or not
	assign consume = ((state_reg == LPC_RUN) & wfe_exec_in) | (state_reg == LPC_WFE);

	lpc_event_gen #(
		.NUM_IRQ(NUM_IRQ)
	) u_event_gen (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.irq_pend_in(irq_pend_in),
		.irq_en_in(irq_en_in),
		.wake_any_in(wake_any_act),
		.sev_in(send_event_instr_in),
		.ext_rise_in(ext_rise),
		.consume_in(consume),
		.event_now_out(event_now),
		.event_latched_out(event_latched_out)
	);

	// Sleep proper ends on an enabled pending interrupt
	assign irq_wake = |(irq_pend_in & irq_en_in);

	// -----------------------------------------------------------------
	// Power state machine
	// -----------------------------------------------------------------
	logic enter_lp;
	logic go_sleep;
	logic skip_wfe;

	// Handler return sleeps only with the flag set
	assign go_sleep = wfi_exec_in | (exc_ret_thread_in & soe_act);
	assign skip_wfe = event_latched_out | event_now;
	// Entry only where the machine really leaves running
	assign enter_lp = (state_reg == LPC_RUN) & (state_next != LPC_RUN);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LPC_RUN: begin
				if (wfe_exec_in) begin
					state_next = skip_wfe ? LPC_RUN : LPC_WFE;
				end else if (go_sleep) begin
					state_next = LPC_SLEEP;
				end
			end
			LPC_WFE: begin
				if (event_now | irq_wake) begin
					state_next = LPC_RUN;
				end
			end
			LPC_SLEEP: begin
				if (irq_wake) begin
					state_next = LPC_RUN;
				end
			end
			default: begin
				state_next = LPC_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= LPC_RUN;
		end else if (ce_in) begin
			state_reg <= state_next;
		end
	end

	// Mode reported to the power controller, fixed at entry
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			deep_out_reg <= LPC_BIT_RST;
		end else if (ce_in && enter_lp) begin
			deep_out_reg <= deep_sel_reg;
		end else if (ce_in && state_next == LPC_RUN) begin
			deep_out_reg <= LPC_BIT_RST;
		end
	end

	// One-cycle pulse on each return to running
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wake_reg <= LPC_BIT_RST;
		end else if (ce_in) begin
			wake_reg <= (state_reg != LPC_RUN) && (state_next == LPC_RUN);
		end
	end

	assign core_halt_out = (state_reg != LPC_RUN);
	assign deep_sleep_out = deep_out_reg;
	assign wake_out = wake_reg;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in || !ce_in);

	a_ns_lock_raz: assert property (
		setup_ph && !pwrite_in && hit_ctrl && !sec_acc && lock_reg
		|=> !prdata_out[LPC_DEEP_BIT] && !prdata_out[LPC_LOCK_BIT])
		else $error("non-secure read leaked locked bits");
	a_ns_lock_wi: assert property (
		wr_ns && lock_reg
		|=> $stable(deep_sel_reg) && $stable(lock_reg))
		else $error("non-secure write changed locked bits");
	a_sec_deep_rw: assert property (
		wr_sec
		|=> deep_sel_reg == $past(pwdata_in[LPC_DEEP_BIT]))
		else $error("secure write to deep select lost");
	a_bank_split: assert property (
		wr_ns
		|=> $stable(wake_any_s_reg) && $stable(soe_s_reg)
		&& wake_any_ns_reg == $past(pwdata_in[LPC_WAKE_BIT]))
		else $error("banked copies mixed");
	a_wfe_skip: assert property (
		state_reg == LPC_RUN && wfe_exec_in && event_latched_out
		|=> state_reg == LPC_RUN && !event_latched_out)
		else $error("latched event did not skip the wait");
	a_wfe_wake: assert property (
		state_reg == LPC_WFE && event_now
		|=> state_reg == LPC_RUN && wake_out ##1 !wake_out)
		else $error("event did not end the wait");
	a_soe_off: assert property (
		state_reg == LPC_RUN && exc_ret_thread_in && !soe_act
		&& !wfi_exec_in && !wfe_exec_in
		|=> !core_halt_out)
		else $error("return slept with flag clear");
	a_soe_on: assert property (
		state_reg == LPC_RUN && exc_ret_thread_in && soe_act && !wfe_exec_in
		|=> state_reg == LPC_SLEEP && deep_sleep_out == $past(deep_sel_reg))
		else $error("return with flag set did not sleep");
	a_mode_held: assert property (
		core_halt_out && $past(core_halt_out)
		|-> $stable(deep_sleep_out))
		else $error("reported sleep mode changed mid-sleep");
	a_run_not_deep: assert property (!core_halt_out |-> !deep_sleep_out)
		else $error("deep sleep reported while running");

	c_wfe_halt: cover property (state_reg == LPC_RUN && wfe_exec_in ##1 state_reg == LPC_WFE
		##[1:20] wake_out);
	c_deep_sleep: cover property (enter_lp && deep_sel_reg ##1 deep_sleep_out);
	c_ns_locked: cover property (wr_ns && lock_reg);
	c_sev_wake: cover property (state_reg == LPC_WFE && send_event_instr_in);

endmodule : lpc_low_power_ctrl

/* lpc_pkg.sv */
// Constants, field layout and state codes for the low-power entry control block
//
// Contract
// - Disabled interrupts never wake when wake-any clear
// - Wake-any set: every newly pending interrupt wakes a halted wait; a sleep still needs an enabled one
// - New pending event wakes a halted wait
// - Event while running is latched for next wait
// - Send-event or external event also wakes
// - Deep-sleep select: 0 sleep, 1 deep
// - Handler-return flag clear: return keeps running
// - Handler-return flag set: return enters low power
// - Lock clear: deep select open to both states
// - Lock set: non-secure deep select reads zero
// - Lock bit itself secure-only, else RAZ/WI
// - Wake-any and handler-return flags banked per state
// - Deep select and lock are single shared copies
package lpc_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam int LPC_ADDR_W = 12;
	localparam logic [LPC_ADDR_W-1:0] LPC_CTRL_OFS = 12'h000;
	localparam logic [LPC_ADDR_W-1:0] LPC_STAT_OFS = 12'h004;

	// Control register fields
	localparam int LPC_SOE_BIT = 1;
	localparam int LPC_DEEP_BIT = 2;
	localparam int LPC_LOCK_BIT = 3;
	localparam int LPC_WAKE_BIT = 4;

	// Status register fields
	localparam int LPC_ST_SLEEP_BIT = 0;
	localparam int LPC_ST_DEEP_BIT = 1;
	localparam int LPC_ST_WFE_BIT = 2;
	localparam int LPC_ST_EVT_BIT = 3;

	// Values after reset
	localparam logic LPC_BIT_RST = 1'b0;
	localparam logic [31:0] LPC_WORD_RST = 32'h0000_0000;

	// -----------------------------------------------------------------
	// Core power states
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		LPC_RUN = 3'h1,
		LPC_WFE = 3'h2,
		LPC_SLEEP = 3'h4
	} lpc_state_e;

endpackage : lpc_pkg

/* lpc_event_gen.sv */
// Wake event generator and event latch for the wait-for-event path
module lpc_event_gen #(
	parameter int NUM_IRQ = 32
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Event sources
	input wire logic [NUM_IRQ-1:0] irq_pend_in,
	input wire logic [NUM_IRQ-1:0] irq_en_in,
	input wire logic wake_any_in,
	input wire logic sev_in,
	input wire logic ext_rise_in,
	input wire logic consume_in,
	// Results
	output logic event_now_out,
	output logic event_latched_out
);
	import lpc_pkg::*;

	logic [NUM_IRQ-1:0] pend_d_reg;
	logic [NUM_IRQ-1:0] pend_rise;
	logic event_reg;
	logic event_next;

	// -----------------------------------------------------------------
	// Per-interrupt pending edge detect
	// -----------------------------------------------------------------
	for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
		always_ff @(posedge core_clk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				pend_d_reg[i] <= LPC_BIT_RST;
			end else if (ce_in) begin
				pend_d_reg[i] <= irq_pend_in[i];
			end
		end
		// Disabled ones count only when wake-any is set
		assign pend_rise[i] = irq_pend_in[i] & ~pend_d_reg[i]
			& (irq_en_in[i] | wake_any_in);
	end

	// Any event source this cycle
	assign event_now_out = (|pend_rise) | sev_in | ext_rise_in;

	// Latch events nobody consumed; a consuming wait swallows a same-cycle event
	assign event_next = (event_now_out | event_reg) & ~consume_in;
	assign event_latched_out = event_reg;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			event_reg <= LPC_BIT_RST;
		end else if (ce_in) begin
			event_reg <= event_next;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in || !ce_in);

	a_disabled_masked: assert property (
		!wake_any_in && !sev_in && !ext_rise_in
		&& ((irq_pend_in & ~pend_d_reg & irq_en_in) == '0)
		|-> !event_now_out)
		else $error("disabled interrupt raised an event");
	a_any_pend_wakes: assert property (
		wake_any_in && ((irq_pend_in & ~pend_d_reg) != '0)
		|-> event_now_out)
		else $error("pending interrupt missed with wake-any set");

endmodule : lpc_event_gen

/* lpc_low_power_ctrl_bench.sv */
// Self-checking bench for the low-power entry control block
module lpc_low_power_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lpc_pkg::*;
	localparam int NIRQ = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [LPC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [2:0] pprot = '0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [3:0] pulse_v = '0;
	logic cur_sec = 1'b1;
	logic ce = 1'b1;
	logic ext_ev = 1'b0;
	logic [NIRQ-1:0] pend = '0;
	logic [NIRQ-1:0] en = '0;
	logic halt;
	logic deep;
	logic wake;
	logic evt;
	int err_total = 0;
	int n_checks = 0;
	logic m_deep = 1'b0;
	logic m_lock = 1'b0;
	logic [1:0] m_wk = '0;
	logic [1:0] m_soe = '0;

	// Clock at 8 ns period
	always #4 clk = ~clk;

	lpc_low_power_ctrl #(.NUM_IRQ(NIRQ), .SEC_EXT(1'b1)) dut_u (
		.core_clk_in(clk), .nrst_in(nrst), .ce_in(ce),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pstrb_in(4'hF), .pprot_in(pprot), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .wfe_exec_in(pulse_v[0]),
		.wfi_exec_in(pulse_v[1]), .exc_ret_thread_in(pulse_v[2]), .cur_secure_in(cur_sec),
		.send_event_instr_in(pulse_v[3]), .ext_event_in(ext_ev), .irq_pend_in(pend),
		.irq_en_in(en), .core_halt_out(halt), .deep_sleep_out(deep), .wake_out(wake),
		.event_latched_out(evt)
	);

	// ----------------------------------------------------------------
	// Verdict, comparison and expectation helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Read value of the control word for one security state
	function automatic logic [31:0] exp_rd(input logic ns);
		return {27'h0, m_wk[ns], ns ? 1'b0 : m_lock, (ns && m_lock) ? 1'b0 : m_deep,
			m_soe[ns], 1'b0};
	endfunction : exp_rd

	// Banked and shared field update on a write
	function automatic void mod_wr(input logic [31:0] d, input logic ns);
		m_wk[ns] = d[LPC_WAKE_BIT];
		m_soe[ns] = d[LPC_SOE_BIT];
		if (!(ns && m_lock)) begin
			m_deep = d[LPC_DEEP_BIT];
		end
		if (!ns) begin
			m_lock = d[LPC_LOCK_BIT];
		end
	endfunction : mod_wr

	// ----------------------------------------------------------------
	// Bus and core drivers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic ns, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pprot <= {1'b0, ns, 1'b0};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			$display("BAD pready expected 1 seen %b", pready);
			stop_test();
		end
	endtask : apb

	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		pulse_v <= v;
		@(posedge clk);
		pulse_v <= 4'h0;
		#1;
	endtask : pulse

	task automatic src(input logic [NIRQ-1:0] p, input logic [NIRQ-1:0] e, input logic x);
		@(posedge clk);
		pend <= p;
		en <= e;
		ext_ev <= x;
	endtask : src

	// Bounded wait for the core to leave the halted state
	task automatic wait_wake(input string nm);
		int n;
		logic w;
		n = 0;
		#1;
		while (halt !== 1'b0 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 10) begin
			err_total++;
			$display("BAD %s expected 0 seen %b", nm, halt);
			stop_test();
		end
		w = wake;
		@(posedge clk);
		#1;
		chk(nm, {31'h0, w | wake}, 32'h1);
		src('0, '0, 1'b0);
	endtask : wait_wake

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic er;
		logic ns;
		logic wr;
		logic [31:0] d;
		logic [NIRQ-1:0] k;
		void'($urandom(99));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, LPC_CTRL_OFS, '0, 1'b0, rd, er);
		chk("ctrl_rst", rd, LPC_WORD_RST);
		apb(1'b0, LPC_STAT_OFS, '0, 1'b0, rd, er);
		chk("stat_rst", rd, LPC_WORD_RST);
		// Secure writes all ones: only the four fields stick
		apb(1'b1, LPC_CTRL_OFS, 32'hFFFF_FFFF, 1'b0, rd, er);
		mod_wr(32'hFFFF_FFFF, 1'b0);
		apb(1'b0, LPC_CTRL_OFS, '0, 1'b1, rd, er);
		chk("ns_locked", rd, exp_rd(1'b1));
		// Random mix of secure and non-secure accesses
		for (int i = 0; i < 60; i++) begin
			ns = 1'($urandom_range(1));
			wr = 1'($urandom_range(1));
			d = $urandom();
			apb(wr, LPC_CTRL_OFS, d, ns, rd, er);
			chk("ctrl_err", {31'h0, er}, 32'h0);
			if (wr) begin
				mod_wr(d, ns);
			end else begin
				chk("ctrl_rd", rd, exp_rd(ns));
			end
		end
		apb(1'b0, 12'h008, '0, 1'b0, rd, er);
		chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, LPC_STAT_OFS, 32'hFFFF_FFFF, 1'b0, rd, er);
		chk("stat_wr", {31'h0, er}, 32'h0);
		apb(1'b1, LPC_CTRL_OFS, 32'h0000_0000, 1'b0, rd, er);
		// Return with flag clear keeps running
		pulse(4'h4);
		chk("ret_run", {31'h0, halt}, 32'h0);
		// Event while running is latched and swallows the next wait
		pulse(4'h8);
		chk("latched", {31'h0, evt}, 32'h1);
		pulse(4'h1);
		chk("wfe_nohalt", {halt, evt}, 32'h0);
		// Disabled interrupt must not wake, enabled one does
		k = NIRQ'(1) << $urandom_range(NIRQ - 1);
		pulse(4'h1);
		chk("wfe_halt", {halt, deep}, 32'h2);
		src(k, '0, 1'b0);
		repeat (4) @(posedge clk);
		#1;
		chk("dis_irq", {31'h0, halt}, 32'h1);
		// Status word while halted in the wait
		apb(1'b0, LPC_STAT_OFS, '0, 1'b0, rd, er);
		chk("stat_wfe", rd, (32'h1 << LPC_ST_SLEEP_BIT) | (32'h1 << LPC_ST_WFE_BIT));
		src(k, k, 1'b0);
		wait_wake("en_irq_wake");
		// Send-event and external pin wake the wait
		pulse(4'h1);
		pulse(4'h8);
		wait_wake("sev_wake");
		pulse(4'h1);
		src('0, '0, 1'b1);
		wait_wake("ext_wake");
		// Wake-any: a disabled interrupt wakes the wait
		apb(1'b1, LPC_CTRL_OFS, 32'h0000_0010, 1'b0, rd, er);
		pulse(4'h1);
		src(k, '0, 1'b0);
		wait_wake("any_wake");
		// Return with flag set enters deep sleep
		apb(1'b1, LPC_CTRL_OFS, 32'h0000_0006, 1'b0, rd, er);
		pulse(4'h4);
		chk("ret_deep", {halt, deep}, 32'h3);
		src(k, k, 1'b0);
		wait_wake("deep_wake");
		chk("deep_clr", {31'h0, deep}, 32'h0);
		// Plain sleep when deep select is clear
		apb(1'b1, LPC_CTRL_OFS, 32'h0000_0000, 1'b0, rd, er);
		pulse(4'h2);
		chk("wfi_sleep", {halt, deep}, 32'h2);
		src(k, k, 1'b0);
		wait_wake("sleep_wake");
		// Non-secure context uses its own handler-return copy
		apb(1'b1, LPC_CTRL_OFS, 32'h0000_0002, 1'b1, rd, er);
		pulse(4'h4);
		chk("bank_s_run", {31'h0, halt}, 32'h0);
		@(posedge clk);
		cur_sec <= 1'b0;
		pulse(4'h4);
		chk("bank_ns_sleep", {halt, deep}, 32'h2);
		src(k, k, 1'b0);
		wait_wake("bank_wake");
		// Interrupt that rose during sleep is left latched
		chk("sleep_latch", {31'h0, evt}, 32'h1);
		pulse(4'h1);
		pulse(4'h1);
		chk("wfe_again", {31'h0, halt}, 32'h1);
		// Clock enable low freezes the wait despite a wake source
		@(posedge clk);
		ce <= 1'b0;
		src(k, k, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk("ce_frozen", {31'h0, halt}, 32'h1);
		@(posedge clk);
		ce <= 1'b1;
		wait_wake("ce_wake");
		stop_test();
	end
endmodule : lpc_low_power_ctrl_bench
